/* File: rtl/gft_ground_fault_trip.sv */
// Overview of operation
// (RULE_01) Run and start delays, 0 to 10 s.
// (RULE_02) Running: trip after run delay above pickup.
// (RULE_03) Starting: trip after start delay above pickup.
// (RULE_04) Phase current rising: start delay until decided.
// (RULE_05) Learned reset: record start capacity, shorten lockout.
// (RULE_06) Learned reset off: lockout until capacity 15%.
// (RULE_07) Learned reset on: 100 minus used minus 2.
// (RULE_08) Ground drop below pickup restarts delay timer.
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module gft_ground_fault_trip
  import gft_pkg::*;
#(
  parameter int TENTH_CYCLES = DELAY_STEP_CYCLES,
  parameter int CUR_W        = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // Measurements and motor state
  input  wire logic [CUR_W-1:0]  groundCurrent,
  input  wire logic [CUR_W-1:0]  groundPickup,
  input  wire logic [CUR_W-1:0]  phaseCurrent,
  input  wire logic              motorStarting,
  input  wire logic              motorRunning,
  input  wire logic              stateDecided,
  input  wire logic [TC_W-1:0]   thermalCap,
  input  wire logic              overloadTrip,
  // Outputs
  output logic      [RELAY_W-1:0] relayOut,
  output logic                    gfTripCause,
  output logic                    overloadLockout,
  output logic                    irq
);

  if (CUR_W < 1 || CUR_W > 32) begin
    $error("CUR_W must lie between 1 and 32");
  end

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic                ack_reg;
  logic                ack_next;
  logic [31:0]         rdata_reg;
  logic [31:0]         rdata_next;
  logic                learn_reg;
  logic                learn_next;
  logic [RELAY_W-1:0]  assign_reg;
  logic [RELAY_W-1:0]  assign_next;
  logic [DELAY_W-1:0]  runDelay_reg;
  logic [DELAY_W-1:0]  runDelay_next;
  logic [DELAY_W-1:0]  startDelay_reg;
  logic [DELAY_W-1:0]  startDelay_next;
  logic [IRQ_W-1:0]    irqStatus_reg;
  logic [IRQ_W-1:0]    irqStatus_next;
  logic [IRQ_W-1:0]    irqMask_reg;
  logic [IRQ_W-1:0]    irqMask_next;

  // ****************************************************************
  // Protection state
  // ****************************************************************
  logic                trip_reg;
  logic                trip_next;
  logic [RELAY_W-1:0]  relay_reg;
  logic [RELAY_W-1:0]  relay_next;
  logic                undecided_reg;
  logic                undecided_next;
  logic                phaseZero_reg;
  logic                phaseZero_next;
  logic                startPrev_reg;
  logic                startPrev_next;
  logic [TC_W-1:0]     tcBase_reg;
  logic [TC_W-1:0]     tcBase_next;
  logic [TC_W-1:0]     tcUsed_reg;
  logic [TC_W-1:0]     tcUsed_next;
  logic                lock_reg;
  logic                lock_next;

  // ****************************************************************
  // Combinational helpers
  // ****************************************************************
  logic                accept;
  logic                wrAccept;
  logic                rdAccept;
  logic                clearTrip;
  logic                aboveP;
  logic                useStart;
  logic                learnedDone;
  logic                released;
  logic [TC_W-1:0]     tcThreshold;
  logic [IRQ_W-1:0]    irqEvents;

  gft_timer_if tif ();

  gft_delay_timer #(
    .TENTH_CYCLES (TENTH_CYCLES)
  ) u_timer (
    .clk   (clk),
    .reset (reset),
    .tif   (tif)
  );

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // Every access waits exactly one cycle so that read data comes from a flip-flop.
  assign waitrequest = (read || write) && !ack_reg;
  assign accept      = (read || write) && ack_reg;
  assign wrAccept    = accept && write;
  assign rdAccept    = accept && read;
  assign clearTrip   = wrAccept && (address == OFS_CTRL) && writedata[CTRL_CLEAR_BIT];

  // ****************************************************************
  // Ground-fault qualification
  // ****************************************************************
  assign aboveP   = groundCurrent >= groundPickup;
  // Until the start detector decides, a fresh current rise is treated as a start.
  assign useStart = undecided_reg || !motorRunning; // RULE_04
  always_comb begin
    tif.over  = aboveP && (motorRunning || motorStarting || undecided_reg); // RULE_02 RULE_03
    tif.delay = useStart ? startDelay_reg : runDelay_reg; // RULE_02 RULE_03
  end

  // ****************************************************************
  // Lockout threshold
  // ****************************************************************
  always_comb begin
    tcThreshold = TC_FIXED; // RULE_06
    if (learn_reg) begin
      if (tcUsed_reg >= (TC_FULL - TC_MARGIN)) begin
        tcThreshold = '0;
      end else begin
        tcThreshold = TC_FULL - tcUsed_reg - TC_MARGIN; // RULE_07
      end
    end
  end

  assign learnedDone = startPrev_reg && !motorStarting && learn_reg;
  assign released    = lock_reg && !overloadTrip && (thermalCap <= tcThreshold);

  always_comb begin
    irqEvents              = '0;
    irqEvents[IRQ_GF_TRIP] = tif.expired && !trip_reg;
    irqEvents[IRQ_RELEASE] = released;
    irqEvents[IRQ_LEARNED] = learnedDone;
  end

  // ****************************************************************
  // Protection next state
  // ****************************************************************
  always_comb begin
    trip_next      = trip_reg;
    undecided_next = undecided_reg;
    startPrev_next = motorStarting;
    tcBase_next    = tcBase_reg;
    tcUsed_next    = tcUsed_reg;
    lock_next      = lock_reg;
    phaseZero_next = (phaseCurrent == '0);

    // A new fault wins over a clear issued in the same cycle.
    if (clearTrip) begin
      trip_next = 1'b0;
    end
    if (tif.expired) begin
      trip_next = 1'b1; // RULE_02 RULE_03
    end
    relay_next = trip_next ? assign_reg : '0; // RULE_02 RULE_03

    if (stateDecided) begin
      undecided_next = 1'b0;
    end
    if (phaseZero_reg && (phaseCurrent != '0)) begin
      undecided_next = 1'b1; // RULE_04
    end

    if (motorStarting && !startPrev_reg) begin
      tcBase_next = thermalCap; // RULE_05
    end
    if (learnedDone) begin
      tcUsed_next = (thermalCap > tcBase_reg) ? (thermalCap - tcBase_reg) : '0; // RULE_05
    end

    if (released) begin
      lock_next = 1'b0; // RULE_06 RULE_07
    end
    if (overloadTrip) begin
      lock_next = 1'b1; // RULE_05
    end
  end

  // ****************************************************************
  // Register next state
  // ****************************************************************
  always_comb begin
    ack_next        = (read || write) && !ack_reg;
    learn_next      = learn_reg;
    assign_next     = assign_reg;
    runDelay_next   = runDelay_reg;
    startDelay_next = startDelay_reg;
    irqMask_next    = irqMask_reg;
    irqStatus_next  = irqStatus_reg;
    rdata_next      = '0;

    if (wrAccept) begin
      case (address)
        OFS_CTRL: begin
          learn_next  = writedata[CTRL_LEARN_BIT];
          assign_next = writedata[CTRL_RELAY_LSB +: RELAY_W];
        end
        OFS_RUN_DELAY: begin
          // Settings above ten seconds are clamped rather than wrapped.
          runDelay_next = (writedata[31:0] > 32'(DELAY_MAX)) ? DELAY_MAX : writedata[DELAY_W-1:0]; // RULE_01
        end
        OFS_START_DELAY: begin
          startDelay_next = (writedata[31:0] > 32'(DELAY_MAX)) ? DELAY_MAX : writedata[DELAY_W-1:0]; // RULE_01
        end
        OFS_IRQ_MASK: begin
          irqMask_next = writedata[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end

    if (rdAccept && (address == OFS_IRQ_STATUS)) begin
      irqStatus_next = '0;
    end
    irqStatus_next = irqStatus_next | irqEvents;

    if ((read || write) && !ack_reg && read) begin
      case (address)
        OFS_CTRL: begin
          rdata_next[CTRL_LEARN_BIT]            = learn_reg;
          rdata_next[CTRL_RELAY_LSB +: RELAY_W] = assign_reg;
        end
        OFS_RUN_DELAY: begin
          rdata_next[DELAY_W-1:0] = runDelay_reg;
        end
        OFS_START_DELAY: begin
          rdata_next[DELAY_W-1:0] = startDelay_reg;
        end
        OFS_STATE: begin
          rdata_next[ST_TRIP_BIT]              = trip_reg;
          rdata_next[ST_LOCK_BIT]              = lock_reg;
          rdata_next[ST_UNDEC_BIT]             = undecided_reg;
          rdata_next[ST_START_BIT]             = useStart;
          rdata_next[ST_USED_LSB +: TC_W]      = tcUsed_reg;
          rdata_next[ST_THR_LSB +: TC_W]       = tcThreshold;
        end
        OFS_IRQ_STATUS: begin
          rdata_next[IRQ_W-1:0] = irqStatus_reg;
        end
        OFS_IRQ_MASK: begin
          rdata_next[IRQ_W-1:0] = irqMask_reg;
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end else if (ack_reg) begin
      rdata_next = rdata_reg;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_reg        <= 1'b0;
      rdata_reg      <= '0;
      learn_reg      <= 1'b0;
      assign_reg     <= RELAY_RESET;
      runDelay_reg   <= DELAY_RESET;
      startDelay_reg <= DELAY_RESET;
      irqStatus_reg  <= '0;
      irqMask_reg    <= '0;
      trip_reg       <= 1'b0;
      relay_reg      <= '0;
      undecided_reg  <= 1'b0;
      phaseZero_reg  <= 1'b1;
      startPrev_reg  <= 1'b0;
      tcBase_reg     <= '0;
      tcUsed_reg     <= '0;
      lock_reg       <= 1'b0;
    end else begin
      ack_reg        <= ack_next;
      rdata_reg      <= rdata_next;
      learn_reg      <= learn_next;
      assign_reg     <= assign_next;
      runDelay_reg   <= runDelay_next;
      startDelay_reg <= startDelay_next;
      irqStatus_reg  <= irqStatus_next;
      irqMask_reg    <= irqMask_next;
      trip_reg       <= trip_next;
      relay_reg      <= relay_next;
      undecided_reg  <= undecided_next;
      phaseZero_reg  <= phaseZero_next;
      startPrev_reg  <= startPrev_next;
      tcBase_reg     <= tcBase_next;
      tcUsed_reg     <= tcUsed_next;
      lock_reg       <= lock_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign readdata        = rdata_reg;
  assign relayOut        = relay_reg;
  assign gfTripCause     = trip_reg;
  assign overloadLockout = lock_reg;
  assign irq             = |(irqStatus_reg & irqMask_reg);

endmodule

/* File: rtl/gft_pkg.sv */
package gft_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS    = 10;
  localparam int DELAY_STEP_NS    = 100_000_000;
  localparam int DELAY_STEP_CYCLES = DELAY_STEP_NS / CLK_PERIOD_NS;

  // ****************************************************************
  // Delay setting, in steps of one tenth of a second
  // ****************************************************************
  localparam int           DELAY_W     = 7;
  localparam logic [6:0]   DELAY_MIN   = 7'h00;
  localparam logic [6:0]   DELAY_MAX   = 7'h64;
  localparam logic [6:0]   DELAY_RESET = 7'h0a;

  // ****************************************************************
  // Thermal capacity, in whole percent
  // ****************************************************************
  localparam int           TC_W        = 7;
  localparam logic [6:0]   TC_FULL     = 7'h64;
  localparam logic [6:0]   TC_FIXED    = 7'h0f;
  localparam logic [6:0]   TC_MARGIN   = 7'h02;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam int           ADDR_W          = 8;
  localparam logic [7:0]   OFS_CTRL        = 8'h00;
  localparam logic [7:0]   OFS_RUN_DELAY   = 8'h04;
  localparam logic [7:0]   OFS_START_DELAY = 8'h08;
  localparam logic [7:0]   OFS_STATE       = 8'h0c;
  localparam logic [7:0]   OFS_IRQ_STATUS  = 8'h10;
  localparam logic [7:0]   OFS_IRQ_MASK    = 8'h14;

  // Control fields.
  localparam int           CTRL_LEARN_BIT  = 0;
  localparam int           CTRL_CLEAR_BIT  = 1;
  localparam int           CTRL_RELAY_LSB  = 4;
  localparam int           RELAY_W         = 4;
  localparam logic [3:0]   RELAY_RESET     = 4'h1;

  // State fields.
  localparam int           ST_TRIP_BIT     = 0;
  localparam int           ST_LOCK_BIT     = 1;
  localparam int           ST_UNDEC_BIT    = 2;
  localparam int           ST_START_BIT    = 3;
  localparam int           ST_USED_LSB     = 8;
  localparam int           ST_THR_LSB      = 16;

  // Interrupt events.
  localparam int           IRQ_W           = 3;
  localparam int           IRQ_GF_TRIP     = 0;
  localparam int           IRQ_RELEASE     = 1;
  localparam int           IRQ_LEARNED     = 2;

endpackage

/* File: rtl/gft_timer_if.sv */
`timescale 1ns/1ns
interface gft_timer_if;
  import gft_pkg::*;

  logic               over;
  logic [DELAY_W-1:0] delay;
  logic               expired;

  modport timer (input over, input delay, output expired);
  modport ctrl  (output over, output delay, input expired);
endinterface

/* File: rtl/gft_delay_timer.sv */
`timescale 1ns/1ns
module gft_delay_timer
  import gft_pkg::*;
#(
  parameter int TENTH_CYCLES = DELAY_STEP_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Qualification
  gft_timer_if.timer tif
);

  localparam int SUB_W = $clog2(TENTH_CYCLES + 1);

  if (TENTH_CYCLES < 1) begin
    $error("TENTH_CYCLES must be at least one");
  end

  logic [SUB_W-1:0]   sub_reg;
  logic [SUB_W-1:0]   sub_next;
  logic [DELAY_W-1:0] tenth_reg;
  logic [DELAY_W-1:0] tenth_next;

  // ****************************************************************
  // Step counting
  // ****************************************************************
  always_comb begin
    sub_next   = sub_reg;
    tenth_next = tenth_reg;
    if (!tif.over) begin
      sub_next   = '0; // RULE_08
      tenth_next = '0; // RULE_08
    end else if (tenth_reg < tif.delay) begin
      if (sub_reg == SUB_W'(TENTH_CYCLES - 1)) begin
        sub_next   = '0;
        tenth_next = tenth_reg + 7'h01;
      end else begin
        sub_next = sub_reg + SUB_W'(1);
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sub_reg   <= '0;
      tenth_reg <= '0;
    end else begin
      sub_reg   <= sub_next;
      tenth_reg <= tenth_next;
    end
  end

  // A zero delay expires in the first cycle above pickup.
  assign tif.expired = tif.over && (tenth_reg >= tif.delay);

endmodule

/* File: test/gft_ground_fault_trip_chk.sv */
`timescale 1ns/1ns
module gft_ground_fault_trip_chk
  import gft_pkg::*;
#(
  parameter int TENTH_CYCLES = DELAY_STEP_CYCLES,
  parameter int CUR_W        = 16
) (
  // Clock and reset
  input wire logic               clk,
  input wire logic               reset,
  // Register bus
  input wire logic [ADDR_W-1:0]  address,
  input wire logic               read,
  input wire logic               write,
  input wire logic [31:0]        writedata,
  input wire logic [31:0]        readdata,
  input wire logic               waitrequest,
  // Measurements
  input wire logic [CUR_W-1:0]   groundCurrent,
  input wire logic [CUR_W-1:0]   groundPickup,
  input wire logic [CUR_W-1:0]   phaseCurrent,
  input wire logic               motorStarting,
  input wire logic               motorRunning,
  input wire logic               stateDecided,
  input wire logic [TC_W-1:0]    thermalCap,
  input wire logic               overloadTrip,
  // Outputs
  input wire logic [RELAY_W-1:0] relayOut,
  input wire logic               gfTripCause,
  input wire logic               overloadLockout,
  input wire logic               irq
);
  logic abovePickup;
  logic clearWrite;

  assign abovePickup = groundCurrent >= groundPickup;
  assign clearWrite  = write && !waitrequest && address == OFS_CTRL && writedata[CTRL_CLEAR_BIT];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_wait_first: assert property ($rose(read || write) |-> waitrequest) else $error("no wait cycle");
  a_wait_second: assert property ((read || write) && waitrequest |=> !waitrequest || !(read || write))
    else $error("wait longer than one cycle");
  a_wait_idle: assert property (!(read || write) |-> !waitrequest) else $error("wait without request");
  a_read_idle: assert property (!read && !$past(read) |-> readdata == 32'h0) else $error("read data not zero");
  a_relay_quiet: assert property (!gfTripCause |-> relayOut == 4'h0) else $error("relay without trip");
  a_trip_cause: assert property ($rose(gfTripCause) |-> $past(abovePickup)) else $error("trip without fault");
  a_trip_hold: assert property (gfTripCause && !clearWrite |=> gfTripCause) else $error("trip lost");
  a_lock_set: assert property (overloadTrip |=> overloadLockout) else $error("lockout not set");
  a_lock_hold: assert property (overloadLockout && thermalCap > 7'h62 |=> overloadLockout)
    else $error("lockout dropped early");
  a_lock_free: assert property (overloadLockout && !overloadTrip && thermalCap == 7'h00 |=> !overloadLockout)
    else $error("lockout stuck");
endmodule

bind gft_ground_fault_trip gft_ground_fault_trip_chk #(.TENTH_CYCLES(TENTH_CYCLES), .CUR_W(CUR_W)) chk (
  .clk(clk), .reset(reset), .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .groundCurrent(groundCurrent), .groundPickup(groundPickup),
  .phaseCurrent(phaseCurrent), .motorStarting(motorStarting), .motorRunning(motorRunning),
  .stateDecided(stateDecided), .thermalCap(thermalCap), .overloadTrip(overloadTrip), .relayOut(relayOut),
  .gfTripCause(gfTripCause), .overloadLockout(overloadLockout), .irq(irq));

/* File: test/gft_motor_model.sv */
`timescale 1ns/1ns
module gft_motor_model
  import gft_pkg::*;
#(
  parameter int CUR_W = 16
) (
  // Commands
  input wire logic          faultOn,
  input wire logic          phaseOn,
  // Sensed currents
  output logic [CUR_W-1:0]  groundCurrent,
  output logic [CUR_W-1:0]  groundPickup,
  output logic [CUR_W-1:0]  phaseCurrent
);
  // A fault sits exactly on the pickup, so the equal case must qualify.
  assign groundPickup  = CUR_W'(16'h0100);
  assign groundCurrent = faultOn ? groundPickup : groundPickup - CUR_W'(16'h0001);
  assign phaseCurrent  = phaseOn ? CUR_W'(16'h0200) : '0;
endmodule

/* File: test/gft_ground_fault_trip_tb_top.sv */
`timescale 1ns/1ns
module gft_ground_fault_trip_tb_top
  import gft_pkg::*;
;
  typedef struct {logic isStart; logic [6:0] wr; logic [6:0] rd;} gft_row_t;
  localparam int T = 4;
  logic clk, reset, read, write, faultOn, phaseOn;
  logic motorStarting, motorRunning, stateDecided, overloadTrip;
  logic gfTripCause, overloadLockout, irq, waitrequest;
  logic [7:0] address;
  logic [31:0] writedata, readdata, d;
  logic [15:0] groundCurrent, groundPickup, phaseCurrent;
  logic [6:0] thermalCap;
  logic [3:0] relayOut;
  int n_mismatch, n_compared, cycles, n;
  gft_row_t rows [5] = '{'{0, 7'h00, 7'h00}, '{0, 7'h01, 7'h01}, '{1, 7'h03, 7'h03},
                         '{1, 7'h7f, 7'h64}, '{0, 7'h64, 7'h64}};

  gft_ground_fault_trip #(.TENTH_CYCLES(T), .CUR_W(16)) dut (
    .clk(clk), .reset(reset), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .groundCurrent(groundCurrent), .groundPickup(groundPickup),
    .phaseCurrent(phaseCurrent), .motorStarting(motorStarting), .motorRunning(motorRunning),
    .stateDecided(stateDecided), .thermalCap(thermalCap), .overloadTrip(overloadTrip), .relayOut(relayOut),
    .gfTripCause(gfTripCause), .overloadLockout(overloadLockout), .irq(irq));
  gft_motor_model #(.CUR_W(16)) model (.faultOn(faultOn), .phaseOn(phaseOn), .groundCurrent(groundCurrent),
    .groundPickup(groundPickup), .phaseCurrent(phaseCurrent));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // The request holds until an edge samples waitrequest low; only the bench timeout ends a hang.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    address <= a;
    writedata <= wd;
    read <= !wr;
    write <= wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic waitTrip();
    n = 0;
    do begin
      @(posedge clk);
      n++;
      @(negedge clk);
    end while (!gfTripCause && n < 600);
    @(posedge clk);
    faultOn <= 1'b0;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    reset = 1'b1; read = 1'b0; write = 1'b0; address = '0; writedata = '0; faultOn = 1'b0; phaseOn = 1'b0;
    motorStarting = 1'b0; motorRunning = 1'b0; stateDecided = 1'b0; thermalCap = '0; overloadTrip = 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    bus(0, OFS_RUN_DELAY, 0);
    check(d, 32'h0a);
    bus(0, OFS_CTRL, 0);
    check(d, 32'h10);
    phaseOn <= 1'b1;
    stateDecided <= 1'b1;
    foreach (rows[i]) begin
      motorRunning <= !rows[i].isStart;
      motorStarting <= rows[i].isStart;
      bus(1, rows[i].isStart ? OFS_START_DELAY : OFS_RUN_DELAY, {25'h0, rows[i].wr});
      bus(0, rows[i].isStart ? OFS_START_DELAY : OFS_RUN_DELAY, 0);
      check(d, {25'h0, rows[i].rd});
      faultOn <= 1'b1;
      waitTrip();
      check(n, rows[i].rd * T + 1);
      check(relayOut, 4'h1);
      bus(1, OFS_CTRL, 32'h12);
    end
    // A one-cycle dip just before expiry must restart the count.
    motorRunning <= 1'b1;
    motorStarting <= 1'b0;
    bus(1, OFS_RUN_DELAY, 2);
    faultOn <= 1'b1;
    repeat (8) @(posedge clk);
    faultOn <= 1'b0;
    @(posedge clk);
    faultOn <= 1'b1;
    waitTrip();
    check(n, 9);
    bus(1, OFS_CTRL, 32'h52);
    bus(0, OFS_IRQ_STATUS, 0);
    check(d, 32'h1);
    check(irq, 0);
    bus(1, OFS_IRQ_MASK, 1);
    bus(1, OFS_START_DELAY, 1);
    phaseOn <= 1'b0;
    stateDecided <= 1'b0;
    repeat (2) @(posedge clk);
    phaseOn <= 1'b1;
    @(posedge clk);
    bus(0, OFS_STATE, 0);
    check(d[3:2], 2'h3);
    faultOn <= 1'b1;
    waitTrip();
    check(n, 5);
    check({irq, relayOut}, 5'h15);
    bus(0, OFS_IRQ_STATUS, 0);
    bus(1, OFS_CTRL, 32'h52);
    @(negedge clk);
    check({irq, gfTripCause}, 0);
    @(posedge clk);
    stateDecided <= 1'b1;
    faultOn <= 1'b1;
    waitTrip();
    check(n, 9);
    bus(1, OFS_CTRL, 32'h12);
    thermalCap <= 7'h10;
    overloadTrip <= 1'b1;
    @(posedge clk);
    overloadTrip <= 1'b0;
    bus(0, OFS_STATE, 0);
    check({d[22:16], 6'h0, d[1]}, {7'h0f, 7'h01});
    thermalCap <= 7'h0f;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(overloadLockout, 0);
    @(posedge clk);
    bus(1, OFS_CTRL, 32'h11);
    motorRunning <= 1'b0;
    thermalCap <= 7'h0a;
    motorStarting <= 1'b1;
    repeat (2) @(posedge clk);
    thermalCap <= 7'h32;
    @(posedge clk);
    motorStarting <= 1'b0;
    motorRunning <= 1'b1;
    repeat (2) @(posedge clk);
    bus(0, OFS_STATE, 0);
    check({d[22:16], d[14:8]}, {7'h3a, 7'h28});
    thermalCap <= 7'h3b;
    overloadTrip <= 1'b1;
    @(posedge clk);
    overloadTrip <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(overloadLockout, 1);
    @(posedge clk);
    thermalCap <= 7'h3a;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(overloadLockout, 0);
    @(posedge clk);
    bus(0, OFS_IRQ_STATUS, 0);
    check(d, 32'h7);
    bus(0, 8'h20, 0);
    check(d, 0);
    summarize();
  end
endmodule
